// >>> rtl/dual_comparator_control.sv
// control and status registers for two comparators on the special-function register space
`timescale 1ns/10ps
`include "cmp_ctrl_cfg.svh"
module dual_comparator_control
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic cmp0_raw,
  input wire logic cmp1_raw,
  output logic cmp0_pin_out,
  output logic cmp1_pin_out,
  output logic cmp0_reset_level,
  output logic cmp0_rise_flag,
  output logic cmp0_fall_flag,
  output logic cmp1_rise_flag,
  output logic cmp1_fall_flag,
  output logic cmp0_on,
  output logic cmp1_on,
  output cmp_ctrl_pkg::hyst_code_type cmp0_pos_hyst_code,
  output cmp_ctrl_pkg::hyst_code_type cmp0_neg_hyst_code,
  output cmp_ctrl_pkg::hyst_code_type cmp1_pos_hyst_code,
  output cmp_ctrl_pkg::hyst_code_type cmp1_neg_hyst_code
);
  import cmp_ctrl_pkg::*;

  top_state_type s;
  top_state_type next_s;
  logic wr0;
  logic wr1;

  cmp_link_if link0();
  cmp_link_if link1();

  // software write plus hardware edges; a detected edge wins over a clearing write
  function automatic cmp_ctrl_type ctrl_update(input cmp_ctrl_type old, input logic wr,
                                               input logic [7:0] wdata, input logic rise,
                                               input logic fall);
    cmp_ctrl_type n;
    n = old;
    if (wr)
    begin
      n.on = wdata[`CMP_ON_BIT];
      n.rise_flag = wdata[`CMP_RISE_BIT];
      n.fall_flag = wdata[`CMP_FALL_BIT];
      n.pos_hyst = hyst_code_type'(wdata[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB]);
      n.neg_hyst = hyst_code_type'(wdata[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB]);
    end
    n.rise_flag = n.rise_flag | rise;
    n.fall_flag = n.fall_flag | fall;
    return n;
  endfunction

  // read image: live result shows low while the comparator is off
  function automatic logic [7:0] pack_ctrl(input cmp_ctrl_type c, input logic result);
    logic [7:0] b;
    b = `CMP_CTRL_RESET;
    b[`CMP_ON_BIT] = c.on;
    b[`CMP_RESULT_BIT] = c.on & result;
    b[`CMP_RISE_BIT] = c.rise_flag;
    b[`CMP_FALL_BIT] = c.fall_flag;
    b[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB] = c.pos_hyst;
    b[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB] = c.neg_hyst;
    return b;
  endfunction

  assign wr0 = sfr_wr && (sfr_addr == `CMP0_CTRL_ADDR);
  assign wr1 = sfr_wr && (sfr_addr == `CMP1_CTRL_ADDR);

  assign link0.on = s.c0.on;
  assign link0.clk_en = clk_en;
  assign link1.on = s.c1.on;
  assign link1.clk_en = clk_en;

  cmp_channel u_chan0
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cmp_raw(cmp0_raw),
    .link(link0.chan)
  );

  cmp_channel u_chan1
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cmp_raw(cmp1_raw),
    .link(link1.chan)
  );

  always_comb
  begin
    next_s = s;
    next_s.c0 = ctrl_update(s.c0, wr0, sfr_wdata, link0.rise, link0.fall);
    next_s.c1 = ctrl_update(s.c1, wr1, sfr_wdata, link1.rise, link1.fall);
    next_s.pin0 = next_s.c0.on & link0.result;
    next_s.pin1 = next_s.c1.on & link1.result;
    if (sfr_rd)
    begin
      case (sfr_addr)
        `CMP0_CTRL_ADDR: next_s.rdata = pack_ctrl(s.c0, link0.result);
        `CMP1_CTRL_ADDR: next_s.rdata = pack_ctrl(s.c1, link1.result);
        default: next_s.rdata = `CMP_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.rdata;
  assign cmp0_pin_out = s.pin0;
  assign cmp1_pin_out = s.pin1;
  // only the first comparator feeds the reset logic
  assign cmp0_reset_level = s.pin0;
  assign cmp0_rise_flag = s.c0.rise_flag;
  assign cmp0_fall_flag = s.c0.fall_flag;
  assign cmp1_rise_flag = s.c1.rise_flag;
  assign cmp1_fall_flag = s.c1.fall_flag;
  assign cmp0_on = s.c0.on;
  assign cmp1_on = s.c1.on;
  assign cmp0_pos_hyst_code = s.c0.pos_hyst;
  assign cmp0_neg_hyst_code = s.c0.neg_hyst;
  assign cmp1_pos_hyst_code = s.c1.pos_hyst;
  assign cmp1_neg_hyst_code = s.c1.neg_hyst;

  chk_enable_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr0) |=> (cmp0_on == $past(sfr_wdata[`CMP_ON_BIT])))
    else $error("enable bit did not follow write");

  chk_pin_low_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!cmp0_on |-> !cmp0_pin_out) and (!cmp1_on |-> !cmp1_pin_out))
    else $error("pin driven high while comparator off");

  chk_pin_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && s.c0.on && !wr0) |=> (cmp0_pin_out == $past(link0.result)))
    else $error("pin did not follow result");

  chk_off_no_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !s.c0.on && !s.c0.rise_flag && !s.c0.fall_flag && !wr0)
    |=> (!cmp0_rise_flag && !cmp0_fall_flag))
    else $error("edge flag set while comparator off");

  chk_read_result: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr == `CMP0_CTRL_ADDR)
    |=> (sfr_rdata[`CMP_RESULT_BIT] == $past(s.c0.on & link0.result)))
    else $error("result bit read wrong");

  chk_rise_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && link0.rise) |=> cmp0_rise_flag)
    else $error("rising edge did not set flag");

  chk_fall_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && link1.fall) |=> cmp1_fall_flag)
    else $error("falling edge did not set flag");

  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmp0_rise_flag && !(clk_en && wr0 && !sfr_wdata[`CMP_RISE_BIT])) |=> cmp0_rise_flag)
    else $error("rise flag dropped without clearing write");

  chk_hyst_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr1) |=> (cmp1_pos_hyst_code == $past(sfr_wdata[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB])
    && cmp1_neg_hyst_code == $past(sfr_wdata[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB])))
    else $error("hysteresis code did not follow write");

  chk_second_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr == `CMP1_CTRL_ADDR)
    |=> (sfr_rdata[`CMP_FALL_BIT] == $past(cmp1_fall_flag) && sfr_rdata[`CMP_ON_BIT] == $past(cmp1_on)))
    else $error("second register read wrong");

  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr != `CMP0_CTRL_ADDR && sfr_addr != `CMP1_CTRL_ADDR)
    |=> (sfr_rdata == `CMP_UNMAPPED_READ))
    else $error("unmapped read not zero");

  chk_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr0 && !sfr_wdata[`CMP_RISE_BIT] && link0.rise) |=> cmp0_rise_flag)
    else $error("clearing write lost a rising edge");

  chk_reset_path: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cmp0_on |-> !cmp0_reset_level)
    else $error("reset level active while comparator off");

  // first comparator: fields move only through writes and detected edges
  chk_on_only_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(clk_en && wr0) |=> $stable(cmp0_on))
    else $error("first enable bit changed without a write");

  chk_first_read_fields: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr == `CMP0_CTRL_ADDR)
    |=> (sfr_rdata[`CMP_ON_BIT] == $past(cmp0_on)
    && sfr_rdata[`CMP_RISE_BIT] == $past(cmp0_rise_flag)
    && sfr_rdata[`CMP_FALL_BIT] == $past(cmp0_fall_flag)
    && sfr_rdata[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB] == $past(cmp0_pos_hyst_code)
    && sfr_rdata[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB] == $past(cmp0_neg_hyst_code)))
    else $error("first register read wrong");

  chk_read_data_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(clk_en && sfr_rd) |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  chk_first_fall_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && link0.fall) |=> cmp0_fall_flag)
    else $error("first falling edge did not set flag");

  chk_rise_needs_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !cmp0_rise_flag && !link0.rise && !(wr0 && sfr_wdata[`CMP_RISE_BIT]))
    |=> !cmp0_rise_flag)
    else $error("rise flag set without an edge");

  chk_fall_needs_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !cmp0_fall_flag && !link0.fall && !(wr0 && sfr_wdata[`CMP_FALL_BIT]))
    |=> !cmp0_fall_flag)
    else $error("fall flag set without an edge");

  chk_fall_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmp0_fall_flag && !(clk_en && wr0 && !sfr_wdata[`CMP_FALL_BIT])) |=> cmp0_fall_flag)
    else $error("fall flag dropped without clearing write");

  chk_clear_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr0 && !sfr_wdata[`CMP_RISE_BIT] && !link0.rise) |=> !cmp0_rise_flag)
    else $error("clearing write left rise flag set");

  chk_write_sets_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr0 && sfr_wdata[`CMP_RISE_BIT]) |=> cmp0_rise_flag)
    else $error("write of one did not set rise flag");

  chk_first_hyst_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr0)
    |=> (cmp0_pos_hyst_code == $past(sfr_wdata[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB])
    && cmp0_neg_hyst_code == $past(sfr_wdata[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB])))
    else $error("first hysteresis code did not follow write");

  chk_hyst_only_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(clk_en && wr0) |=> ($stable(cmp0_pos_hyst_code) && $stable(cmp0_neg_hyst_code)))
    else $error("first hysteresis code changed without a write");

  chk_unmapped_no_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_wr && sfr_addr != `CMP0_CTRL_ADDR && sfr_addr != `CMP1_CTRL_ADDR)
    |=> ($stable(cmp0_on) && $stable(cmp1_on)
    && $stable(cmp0_pos_hyst_code) && $stable(cmp1_pos_hyst_code)
    && $stable(cmp0_neg_hyst_code) && $stable(cmp1_neg_hyst_code)))
    else $error("unmapped write changed a register");

  // second comparator mirrors the first at the next address
  chk_second_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr1) |=> (cmp1_on == $past(sfr_wdata[`CMP_ON_BIT])))
    else $error("second enable bit did not follow write");

  chk_second_on_held: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(clk_en && wr1) |=> $stable(cmp1_on))
    else $error("second enable bit changed without a write");

  chk_second_pin_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && s.c1.on && !wr1) |=> (cmp1_pin_out == $past(link1.result)))
    else $error("second pin did not follow result");

  chk_second_off_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !s.c1.on && !s.c1.rise_flag && !s.c1.fall_flag && !wr1)
    |=> (!cmp1_rise_flag && !cmp1_fall_flag))
    else $error("second edge flag set while comparator off");

  chk_second_result_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr == `CMP1_CTRL_ADDR)
    |=> (sfr_rdata[`CMP_RESULT_BIT] == $past(s.c1.on & link1.result)))
    else $error("second result bit read wrong");

  chk_second_read_rest: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && sfr_rd && sfr_addr == `CMP1_CTRL_ADDR)
    |=> (sfr_rdata[`CMP_RISE_BIT] == $past(cmp1_rise_flag)
    && sfr_rdata[`CMP_POS_HYST_MSB:`CMP_POS_HYST_LSB] == $past(cmp1_pos_hyst_code)
    && sfr_rdata[`CMP_NEG_HYST_MSB:`CMP_NEG_HYST_LSB] == $past(cmp1_neg_hyst_code)))
    else $error("second register fields read wrong");

  chk_second_rise_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && link1.rise) |=> cmp1_rise_flag)
    else $error("second rising edge did not set flag");

  chk_second_needs_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((clk_en && !cmp1_rise_flag && !link1.rise && !(wr1 && sfr_wdata[`CMP_RISE_BIT])) |=> !cmp1_rise_flag)
    and ((clk_en && !cmp1_fall_flag && !link1.fall && !(wr1 && sfr_wdata[`CMP_FALL_BIT])) |=> !cmp1_fall_flag))
    else $error("second edge flag set without an edge");

  chk_second_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((cmp1_rise_flag && !(clk_en && wr1 && !sfr_wdata[`CMP_RISE_BIT])) |=> cmp1_rise_flag)
    and ((cmp1_fall_flag && !(clk_en && wr1 && !sfr_wdata[`CMP_FALL_BIT])) |=> cmp1_fall_flag))
    else $error("second edge flag dropped without clearing write");

  chk_second_clear_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr1 && !sfr_wdata[`CMP_FALL_BIT] && !link1.fall) |=> !cmp1_fall_flag)
    else $error("clearing write left second fall flag set");

  chk_second_hyst_held: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(clk_en && wr1) |=> ($stable(cmp1_pos_hyst_code) && $stable(cmp1_neg_hyst_code)))
    else $error("second hysteresis code changed without a write");

  chk_second_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && wr1 && !sfr_wdata[`CMP_RISE_BIT] && link1.rise) |=> cmp1_rise_flag)
    else $error("clearing write lost a second rising edge");
endmodule

// >>> rtl/cmp_ctrl_cfg.svh
// offsets, field positions and reset values of the dual comparator control block
// Summary of operation
// - bit 7 turns comparator on or off
// - shut-down comparator drives its pin low
// - shut-down comparator sets no edge flags
// - bit 6 reads the live comparator result
// - result readable any time or used for interrupts
// - rising, falling or both edges flag interrupts
// - bit 5 set on low-to-high transition
// - bit 4 set on high-to-low transition
// - edge flags stay set until software writes 0
// - bits 3-2 positive hysteresis code to analog
// - bits 1-0 negative hysteresis code to analog
// - second comparator identical except for the reset path, register at next address
// - only first comparator offers a reset path
`ifndef CMP_CTRL_CFG_SVH
`define CMP_CTRL_CFG_SVH

`define CMP0_CTRL_ADDR 8'h9E
`define CMP1_CTRL_ADDR 8'h9F
`define CMP_ON_BIT 7
`define CMP_RESULT_BIT 6
`define CMP_RISE_BIT 5
`define CMP_FALL_BIT 4
`define CMP_POS_HYST_MSB 3
`define CMP_POS_HYST_LSB 2
`define CMP_NEG_HYST_MSB 1
`define CMP_NEG_HYST_LSB 0
`define CMP_CTRL_RESET 8'h00
`define CMP_UNMAPPED_READ 8'h00

`endif

// >>> rtl/cmp_ctrl_pkg.sv
// types shared by the dual comparator control block
package cmp_ctrl_pkg;

  typedef enum logic [1:0]
  {
    HYST_OFF = 2'b00,
    HYST_2MV = 2'b01,
    HYST_4MV = 2'b10,
    HYST_10MV = 2'b11
  } hyst_code_type;

  // stored fields of one control register; the result bit is live, not stored
  typedef struct packed
  {
    logic on;
    logic rise_flag;
    logic fall_flag;
    hyst_code_type pos_hyst;
    hyst_code_type neg_hyst;
  } cmp_ctrl_type;

  typedef struct packed
  {
    cmp_ctrl_type c0;
    cmp_ctrl_type c1;
    logic [7:0] rdata;
    logic pin0;
    logic pin1;
  } top_state_type;

  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic prev;
  } chan_state_type;

endpackage

// >>> rtl/cmp_link_if.sv
// link between the register file and one comparator input channel
`timescale 1ns/10ps
interface cmp_link_if;
  logic on;
  logic clk_en;
  logic result;
  logic rise;
  logic fall;

  modport ctrl
  (
    output on,
    output clk_en,
    input result,
    input rise,
    input fall
  );

  modport chan
  (
    input on,
    input clk_en,
    output result,
    output rise,
    output fall
  );
endinterface

// >>> rtl/cmp_channel.sv
// synchroniser and edge detector for one comparator output
`timescale 1ns/10ps
`include "cmp_ctrl_cfg.svh"
module cmp_channel
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmp_raw,
  cmp_link_if.chan link
);
  import cmp_ctrl_pkg::*;

  chan_state_type s;
  chan_state_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.sync1 = cmp_raw;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else if (link.clk_en)
    begin
      s <= next_s;
    end
  end

  // edges seen only on the synchronised copy, and only while switched on
  assign link.rise = link.on & s.sync2 & ~s.prev;
  assign link.fall = link.on & ~s.sync2 & s.prev;
  assign link.result = s.sync2;

  chk_edge_once: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((link.clk_en && link.rise) |=> !link.rise) and ((link.clk_en && link.fall) |=> !link.fall))
    else $error("edge pulse lasted more than one enabled cycle");

  chk_rise_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
    (link.clk_en && link.on && !s.sync2 && s.sync1) |=> link.rise || !link.on)
    else $error("rising transition did not raise edge pulse");

  chk_off_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    !link.on |-> !(link.rise || link.fall))
    else $error("edge pulse while comparator off");
endmodule

// >>> dv/cmp_stage_model.sv
// behavioural analog comparator stages feeding the two raw outputs
`timescale 1ns/10ps
module cmp_stage_model
#(
  parameter int RESP_NS = 2
)
(
  input wire logic [1:0] level,
  output logic [1:0] raw
);
  // level is the sign of plus minus the minus input; output settles after a short response
  assign #(RESP_NS) raw = level;
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module tb_top;
  import cmp_ctrl_pkg::*;
  logic ref_clk, resetn, clk_en, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] level, raw, rise, fall, pin;
  logic cmp0_reset_level, cmp0_on, cmp1_on, cmp0_rise_flag, cmp0_fall_flag, cmp1_rise_flag, cmp1_fall_flag;
  logic cmp0_pin_out, cmp1_pin_out;
  hyst_code_type cmp0_pos_hyst_code, cmp0_neg_hyst_code, cmp1_pos_hyst_code, cmp1_neg_hyst_code;
  logic [4:0] cfg [2];
  int mismatches = 0;
  int comparisons = 0;
  // rows: write address, write data, read address, expected read data
  localparam logic [31:0] rows [10] = '{32'h9E8F9E8F, 32'h9EC49E84, 32'h9E309E30, 32'h9E009E00, 32'h9F8B9F8B,
    32'h9F769F36, 32'h9F009F00, 32'hA0FFA000, 32'h9D559E00, 32'h9E819F00};
  assign rise = {cmp1_rise_flag, cmp0_rise_flag};
  assign fall = {cmp1_fall_flag, cmp0_fall_flag};
  assign pin = {cmp1_pin_out, cmp0_pin_out};
  assign cfg[0] = {cmp0_on, cmp0_pos_hyst_code, cmp0_neg_hyst_code};
  assign cfg[1] = {cmp1_on, cmp1_pos_hyst_code, cmp1_neg_hyst_code};

  cmp_stage_model stages (.level(level), .raw(raw));

  dual_comparator_control dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp0_raw(raw[0]),
    .cmp1_raw(raw[1]), .cmp0_pin_out(cmp0_pin_out), .cmp1_pin_out(cmp1_pin_out),
    .cmp0_reset_level(cmp0_reset_level), .cmp0_rise_flag(cmp0_rise_flag), .cmp0_fall_flag(cmp0_fall_flag),
    .cmp1_rise_flag(cmp1_rise_flag), .cmp1_fall_flag(cmp1_fall_flag), .cmp0_on(cmp0_on), .cmp1_on(cmp1_on),
    .cmp0_pos_hyst_code(cmp0_pos_hyst_code), .cmp0_neg_hyst_code(cmp0_neg_hyst_code),
    .cmp1_pos_hyst_code(cmp1_pos_hyst_code), .cmp1_neg_hyst_code(cmp1_neg_hyst_code));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    check_byte(sfr_rdata, exp, "read data");
  endtask

  task automatic set_level(input int n, input logic v);
    @(posedge ref_clk);
    level[n] <= v;
  endtask

  // one channel: edges while on, sticky flags, edge against a clearing write, then shut down
  task automatic channel(input int n);
    logic [7:0] a;
    a = 8'h9E + n[7:0];
    wr(a, 8'h80);
    set_level(n, 1'b1);
    tick(3);
    check_bit(rise[n], 1'b1, "rise flag");
    check_bit(pin[n], 1'b1, "pin output");
    if (n == 0)
      check_bit(cmp0_reset_level, 1'b1, "reset level");
    tick(12);
    rd_chk(a, 8'hE0);
    wr(a, 8'h80);
    rd_chk(a, 8'hC0);
    set_level(n, 1'b0);
    tick(3);
    check_bit(fall[n], 1'b1, "fall flag");
    rd_chk(a, 8'h90);
    wr(a, 8'h80);
    set_level(n, 1'b1);
    @(posedge ref_clk);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= 8'h80;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    tick(0);
    check_bit(rise[n], 1'b1, "edge against clear");
    wr(a, 8'h00);
    set_level(n, 1'b0);
    tick(4);
    check_bit(fall[n], 1'b0, "fall while off");
    set_level(n, 1'b1);
    tick(4);
    check_bit(pin[n], 1'b0, "pin while off");
    rd_chk(a, 8'h00);
    set_level(n, 1'b0);
  endtask

  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end

  initial
  begin
    resetn = 1'b0;
    clk_en = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    level = 2'b00;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk(8'h9E, 8'h00);
    rd_chk(8'h9F, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd_chk(rows[i][15:8], rows[i][7:0]);
      if (rows[i][31:24] == rows[i][15:8])
        check_byte({3'h0, cfg[rows[i][24]]}, {3'h0, rows[i][7], rows[i][3:0]}, "config outputs");
    end
    channel(0);
    channel(1);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(8'h9E, 8'h8C);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_chk(8'h9E, 8'h00);
    wr(8'h9F, 8'h8F);
    @(posedge ref_clk);
    resetn <= 1'b0;
    tick(2);
    check_byte({3'h0, cfg[1]}, 8'h00, "config in reset");
    @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk(8'h9F, 8'h00);
    conclude();
  end
endmodule
